/* design/ltts_seq.sv */
/*
 * Start-up part of the transmitter training sequencer: timers, received
 * and transmitted frame variables, initialisation and lock states.
 * Assumes frame decode, tap machines and later states sit outside and
 * that all link inputs are synchronous to clock.
 */
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ltts_regs.svh"

module ltts_seq #(
	parameter int FAIL_CYC = `LTTS_FAIL_CYC,
	parameter int TEST_CYC = `LTTS_TEST_CYC
) (
	// Clock, reset and enable.
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// AXI4-Lite slave.
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Decoded received training frame.
	input  wire logic        word_sync,
	input  wire logic        rx_frame_valid,
	input  wire logic        rx_preset,
	input  wire logic        rx_initialize,
	input  wire logic        rx_fec_request,
	input  wire logic [5:0]  rx_tap_update,
	input  wire logic        rx_training_complete,
	input  wire logic        rx_sequence_bit,
	input  wire logic        rx_fec_capability,
	input  wire logic        rx_training_flag,
	input  wire logic [5:0]  rx_tap_status,
	// Received variables.
	output logic             in_preset,
	output logic             in_initialize,
	output logic             in_fec_request,
	output logic [5:0]       in_tap_update,
	output logic             in_training_complete,
	output logic             in_sequence_bit,
	output logic             in_fec_capability,
	output logic             in_training_flag,
	output logic [5:0]       in_tap_status,
	// Transmitted variables.
	output logic             out_preset,
	output logic             out_initialize,
	output logic             out_fec_request,
	output logic [5:0]       out_tap_update,
	output logic             out_training_complete,
	output logic             out_sequence_bit,
	output logic             out_fec_capability,
	output logic             out_training_flag,
	output logic [5:0]       out_tap_status,
	output logic [1:0]       out_ext_marker,
	// Transmitter and neighbouring machines.
	output logic             tx_training_signal,
	output logic             coef_load_init,
	output logic             tap_request_start,
	output logic             tap_answer_start,
	output logic             enter_local,
	output logic             train_failed,
	output logic             fail_expired,
	// Link-wait and link-test timers for later states.
	input  wire logic        link_wait_start,
	output logic             link_wait_expired,
	input  wire logic        link_test_start,
	output logic             link_test_expired
);
	import ltts_pkg::*;

	// ---------------------------------------------------------------
	// Timer helper
	// ---------------------------------------------------------------
	// Saturating step shared by the three timers.
	function automatic logic [24:0] tmr_step(input logic [24:0] c,
			input logic [24:0] lim);
		tmr_step = (c < lim) ? c + 25'h0000001 : c;
	endfunction

	ltts_state_t state_q;
	logic [4:0]  ctrl_q;
	logic        start_q;
	logic        init_go;
	logic [24:0] fail_cnt_q;
	logic [24:0] wait_cnt_q;
	logic [24:0] test_cnt_q;
	logic        fail_run_q;
	logic        wait_run_q;
	logic        test_run_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic [3:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;

	// Entry into initialisation; everything moves only with clk_en.
	assign init_go = clk_en && start_q;

	// ---------------------------------------------------------------
	// Timers
	// ---------------------------------------------------------------
	// Each timer counts clock cycles up to the least legal expiry, so
	// the expiry lands at the start of the allowed window. [R19]
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fail_cnt_q   <= 25'h0000000;
			fail_run_q   <= 1'b0;
			fail_expired <= 1'b0;
		end else if (init_go) begin
			fail_cnt_q   <= 25'h0000000; // [R14]
			fail_run_q   <= 1'b1;
			fail_expired <= 1'b0;
		end else if (clk_en && fail_run_q) begin
			fail_cnt_q   <= tmr_step(fail_cnt_q, 25'(FAIL_CYC - 1));
			fail_expired <= fail_cnt_q == 25'(FAIL_CYC - 1); // [R02]
			fail_run_q   <= fail_cnt_q != 25'(FAIL_CYC - 1);
		end
	end

	// Link-wait timer, started by the later ready state.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wait_cnt_q        <= 25'h0000000;
			wait_run_q        <= 1'b0;
			link_wait_expired <= 1'b0;
		end else if (clk_en && link_wait_start) begin
			wait_cnt_q        <= 25'h0000000;
			wait_run_q        <= 1'b1;
			link_wait_expired <= 1'b0;
		end else if (clk_en && wait_run_q) begin
			wait_cnt_q        <= tmr_step(wait_cnt_q, 25'(`LTTS_WAIT_CYC - 1));
			link_wait_expired <= wait_cnt_q == 25'(`LTTS_WAIT_CYC - 1); // [R03]
			wait_run_q        <= wait_cnt_q != 25'(`LTTS_WAIT_CYC - 1);
		end
	end

	// Link-test timer, started by the link quality check.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			test_cnt_q        <= 25'h0000000;
			test_run_q        <= 1'b0;
			link_test_expired <= 1'b0;
		end else if (clk_en && link_test_start) begin
			test_cnt_q        <= 25'h0000000;
			test_run_q        <= 1'b1;
			link_test_expired <= 1'b0;
		end else if (clk_en && test_run_q) begin
			test_cnt_q        <= tmr_step(test_cnt_q, 25'(TEST_CYC - 1));
			link_test_expired <= test_cnt_q == 25'(TEST_CYC - 1); // [R04]
			test_run_q        <= test_cnt_q != 25'(TEST_CYC - 1);
		end
	end

	// ---------------------------------------------------------------
	// Received variables
	// ---------------------------------------------------------------
	// Initialisation wins over a frame in the same cycle, since the
	// entry actions define the starting point of the negotiation.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			in_preset            <= 1'b0;
			in_initialize        <= 1'b0;
			in_fec_request       <= 1'b0;
			in_tap_update        <= `LTTS_UPD_HOLD;
			in_training_complete <= 1'b0;
			in_sequence_bit      <= 1'b1;
			in_fec_capability    <= 1'b0;
			in_training_flag     <= 1'b1;
			in_tap_status        <= `LTTS_UPD_HOLD;
		end else if (init_go) begin
			in_preset            <= 1'b0; // [R08]
			in_initialize        <= 1'b0;
			in_fec_request       <= 1'b0;
			in_tap_update        <= `LTTS_UPD_HOLD;
			in_training_complete <= 1'b0;
			in_sequence_bit      <= 1'b1;
			in_fec_capability    <= 1'b0;
			in_training_flag     <= 1'b1;
			in_tap_status        <= `LTTS_UPD_HOLD;
		end else if (clk_en && rx_frame_valid && word_sync) begin // [R05]
			in_preset            <= rx_preset; // [R06]
			in_initialize        <= rx_initialize;
			in_fec_request       <= rx_fec_request;
			in_tap_update        <= rx_tap_update;
			in_training_complete <= rx_training_complete;
			in_sequence_bit      <= rx_sequence_bit;
			in_fec_capability    <= rx_fec_capability;
			in_training_flag     <= rx_training_flag;
			in_tap_status        <= rx_tap_status;
		end
	end

	// ---------------------------------------------------------------
	// Transmitted variables
	// ---------------------------------------------------------------
	// These feed every frame built from now on; FEC and flag values are
	// only written on entry, so they stay fixed through training. [R07]
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			out_preset            <= 1'b0;
			out_initialize        <= 1'b0;
			out_fec_request       <= 1'b0;
			out_tap_update        <= `LTTS_UPD_HOLD;
			out_training_complete <= 1'b0;
			out_sequence_bit      <= 1'b0;
			out_fec_capability    <= 1'b0;
			out_training_flag     <= 1'b1;
			out_tap_status        <= `LTTS_UPD_HOLD;
			out_ext_marker        <= `LTTS_MARK_LO;
		end else if (init_go) begin
			out_preset            <= 1'b0; // [R09]
			out_initialize        <= 1'b0;
			out_tap_update        <= `LTTS_UPD_HOLD;
			out_training_complete <= 1'b0;
			out_sequence_bit      <= 1'b0;
			out_tap_status        <= `LTTS_UPD_HOLD;
			out_fec_request       <= ctrl_q[`LTTS_CTRL_FECREQ - 1]; // [R10]
			out_fec_capability    <= ctrl_q[`LTTS_CTRL_FECSUP - 1];
			out_training_flag     <= !ctrl_q[`LTTS_CTRL_ALLOW - 1]; // [R11]
			out_ext_marker        <= ctrl_q[`LTTS_CTRL_HIRATE - 1] ?
				`LTTS_MARK_HI : `LTTS_MARK_LO; // [R12]
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// Start pulses go to the six tap machines outside. [R01]
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			coef_load_init    <= 1'b0;
			tap_request_start <= 1'b0;
			tap_answer_start  <= 1'b0;
		end else if (clk_en) begin
			coef_load_init    <= start_q; // [R13]
			tap_request_start <= start_q && ctrl_q[`LTTS_CTRL_SUPP - 1]; // [R14]
			tap_answer_start  <= start_q;
		end
	end

	// Sequence states from initialisation through lock.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_q            <= LTTS_IDLE;
			tx_training_signal <= 1'b0;
			enter_local        <= 1'b0;
			train_failed       <= 1'b0;
		end else if (init_go) begin
			state_q            <= LTTS_INIT;
			tx_training_signal <= 1'b1; // [R13]
			enter_local        <= 1'b0;
			train_failed       <= 1'b0;
		end else if (clk_en) begin
			enter_local <= 1'b0;
			unique case (state_q)
				LTTS_IDLE, LTTS_LOCAL: begin
				end
				LTTS_INIT: begin
					if (fail_expired) begin
						state_q      <= LTTS_FAIL; // [R16]
						train_failed <= 1'b1;
					end else if (!in_sequence_bit) begin
						state_q <= LTTS_LOCK; // [R15] [R17]
					end
				end
				LTTS_LOCK: begin
					if (fail_expired) begin
						state_q      <= LTTS_FAIL; // [R18]
						train_failed <= 1'b1;
					end else if (word_sync) begin
						state_q     <= LTTS_LOCAL;
						enter_local <= 1'b1;
					end
				end
				LTTS_FAIL: begin
					tx_training_signal <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	// Address and data are taken in either order and held until both
	// are present; one write and one read at a time.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `LTTS_RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 4'h0;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			ctrl_q        <= `LTTS_CTRL_RST;
			start_q       <= 1'b0;
		end else if (clk_en) begin
			if (start_q)
				start_q <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q      <= s_axi_awaddr;
				aw_have_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_have_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_q && w_have_q && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				if (awaddr_q == `LTTS_OFF_CTRL) begin
					s_axi_bresp <= `LTTS_RESP_OKAY;
					if (wstrb_q[0]) begin
						ctrl_q  <= wdata_q[`LTTS_CTRL_HIRATE:`LTTS_CTRL_FECREQ];
						start_q <= wdata_q[`LTTS_CTRL_START];
					end
				end else if (awaddr_q == `LTTS_OFF_STATUS ||
						awaddr_q == `LTTS_OFF_RXVAR ||
						awaddr_q == `LTTS_OFF_TXVAR) begin
					s_axi_bresp <= `LTTS_RESP_OKAY;
				end else begin
					s_axi_bresp <= `LTTS_RESP_DECERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_have_q     <= 1'b0;
				w_have_q      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read channel: data is captured at the address handshake.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `LTTS_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `LTTS_RESP_OKAY;
				unique case (s_axi_araddr)
					`LTTS_OFF_CTRL:
						s_axi_rdata <= {26'h0, ctrl_q, 1'b0};
					`LTTS_OFF_STATUS:
						s_axi_rdata <= {25'h0, tx_training_signal, train_failed,
							fail_expired, 1'b0, state_q};
					`LTTS_OFF_RXVAR:
						s_axi_rdata <= {13'h0, in_tap_status, in_training_flag,
							in_fec_capability, in_sequence_bit, in_training_complete,
							in_tap_update, in_fec_request, in_initialize, in_preset};
					`LTTS_OFF_TXVAR:
						s_axi_rdata <= {11'h0, out_ext_marker, out_tap_status,
							out_training_flag, out_fec_capability, out_sequence_bit,
							out_training_complete, out_tap_update, out_fec_request,
							out_initialize, out_preset};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `LTTS_RESP_DECERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	rx_hold_a: assert property (@(posedge clock) disable iff (!resetn) // [R05]
		!(clk_en && rx_frame_valid && word_sync) && !init_go
		|=> $stable(in_tap_status) && $stable(in_sequence_bit))
		else $error("received variables changed without synced frame");
	rx_capture_a: assert property (@(posedge clock) disable iff (!resetn) // [R06]
		clk_en && rx_frame_valid && word_sync && !init_go
		|=> in_tap_update == $past(rx_tap_update) && in_training_flag == $past(rx_training_flag))
		else $error("synced frame not captured");
	rx_init_a: assert property (@(posedge clock) disable iff (!resetn) // [R08]
		init_go |=> in_sequence_bit && in_training_flag && in_tap_status == 6'h00
		&& !in_training_complete)
		else $error("received variables not initialised");
	tx_init_a: assert property (@(posedge clock) disable iff (!resetn) // [R09]
		init_go |=> !out_sequence_bit && out_tap_update == 6'h00
		&& out_fec_request == $past(ctrl_q[0]) && out_training_flag == !$past(ctrl_q[2]))
		else $error("transmit variables not initialised");
	marker_a: assert property (@(posedge clock) disable iff (!resetn) // [R12]
		init_go |=> out_ext_marker == ($past(ctrl_q[4]) ? 2'h3 : 2'h0))
		else $error("extended marker wrong");
	start_pulse_a: assert property (@(posedge clock) disable iff (!resetn) // [R14]
		init_go |=> tap_answer_start && coef_load_init && tx_training_signal
		&& tap_request_start == $past(ctrl_q[3]) && fail_run_q)
		else $error("start actions missing");
	to_lock_a: assert property (@(posedge clock) disable iff (!resetn) // [R15]
		clk_en && !init_go && state_q == LTTS_INIT && !in_sequence_bit && !fail_expired
		|=> state_q == LTTS_LOCK)
		else $error("no move to lock");
	fail_exit_a: assert property (@(posedge clock) disable iff (!resetn) // [R16]
		clk_en && !init_go && fail_expired && state_q inside {LTTS_INIT, LTTS_LOCK}
		|=> state_q == LTTS_FAIL && train_failed)
		else $error("fail timer expiry ignored");
	fail_time_a: assert property (@(posedge clock) disable iff (!resetn) // [R02]
		$rose(fail_expired) |-> fail_cnt_q == 25'(FAIL_CYC - 1))
		else $error("fail timer expired at wrong count");
	wait_time_a: assert property (@(posedge clock) disable iff (!resetn) // [R03]
		$rose(link_wait_expired) |-> wait_cnt_q == 25'(`LTTS_WAIT_CYC - 1))
		else $error("link wait expired at wrong count");
	init_c: cover property (@(posedge clock) disable iff (!resetn) init_go);
	lock_c: cover property (@(posedge clock) disable iff (!resetn) enter_local);
	fail_c: cover property (@(posedge clock) disable iff (!resetn) $rose(train_failed));
endmodule

`default_nettype wire

/* inc/ltts_regs.svh */
/*
 * Register map, field positions, reset values and timer figures of the
 * link training sequencer start-up block.
 * Assumes a 20 MHz clock and a 32-bit AXI4-Lite register bus.
 */
// Notes on behaviour
// R01: Sequencer, three tap request, three tap answer machines.
// R02: Failure timer expires between 1 s and 1.5 s.
// R03: Link-wait timer expires between 32 and 96 us.
// R04: Link-test timer expires between 30 and 45 ms.
// R05: Received variables update only with word sync.
// R06: Capture all control and status fields received.
// R07: Transmit variables feed every frame sent afterwards.
// R08: Init clears received variables, sequence and flag one.
// R09: Init zeroes transmit preset, init, complete, sequence, taps.
// R10: FEC request and capability follow port settings.
// R11: Training flag is inverse of training allowed.
// R12: Extended marker 11b at top rates, else 00b.
// R13: Load initialize coefficients, then send training signal.
// R14: Start requesters if supported, answerers, then fail timer.
// R15: Received sequence bit zero moves to lock state.
// R16: Fail timer expiry in init reports failure.
// R17: Remote sends sequence zero when ready.
// R18: Lock: word sync goes local, expiry fails.
// R19: Timers are clock counters sized from clock rate.
`ifndef LTTS_REGS_SVH
`define LTTS_REGS_SVH

// ---------------------------------------------------------------
// Register offsets and fields
// ---------------------------------------------------------------
`define LTTS_OFF_CTRL    4'h0
`define LTTS_OFF_STATUS  4'h4
`define LTTS_OFF_RXVAR   4'h8
`define LTTS_OFF_TXVAR   4'hC
`define LTTS_CTRL_START  0
`define LTTS_CTRL_FECREQ 1
`define LTTS_CTRL_FECSUP 2
`define LTTS_CTRL_ALLOW  3
`define LTTS_CTRL_SUPP   4
`define LTTS_CTRL_HIRATE 5
`define LTTS_CTRL_RST    5'h00
`define LTTS_RESP_OKAY   2'h0
`define LTTS_RESP_DECERR 2'h3
`define LTTS_MARK_HI     2'h3
`define LTTS_MARK_LO     2'h0
`define LTTS_UPD_HOLD    6'h00

// ---------------------------------------------------------------
// Timer figures
// ---------------------------------------------------------------
`define LTTS_CLK_HZ      20000000
`define LTTS_FAIL_MS     1000
`define LTTS_WAIT_US     32
`define LTTS_TEST_MS     30
`define LTTS_FAIL_CYC    ((`LTTS_CLK_HZ / 1000) * `LTTS_FAIL_MS)
`define LTTS_WAIT_CYC    ((`LTTS_CLK_HZ / 1000000) * `LTTS_WAIT_US)
`define LTTS_TEST_CYC    ((`LTTS_CLK_HZ / 1000) * `LTTS_TEST_MS)

`endif

/* inc/ltts_pkg.sv */
/*
 * Types used by the training sequencer start-up block.
 * Assumes nothing of its surroundings.
 */
package ltts_pkg;
	typedef enum logic [2:0] {
		LTTS_IDLE,
		LTTS_INIT,
		LTTS_LOCK,
		LTTS_LOCAL,
		LTTS_FAIL
	} ltts_state_t;
	typedef logic [1:0] ltts_tap_t;
endpackage

/* test/ltts_remote.sv */
/*
 * Remote link port model: emits decoded training frames towards the block.
 * Assumes the bench sets readiness, word sync and the frame field pattern.
 */
`timescale 1ns/1ps
`default_nettype none

module ltts_remote (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        resetn,
	// Bench controls.
	input  wire logic        sync_en,
	input  wire logic        ready,
	input  wire logic [17:0] fields,
	// Decoded frame towards the block.
	output logic             word_sync,
	output logic             rx_frame_valid,
	output logic             rx_preset,
	output logic             rx_initialize,
	output logic             rx_fec_request,
	output logic [5:0]       rx_tap_update,
	output logic             rx_training_complete,
	output logic             rx_sequence_bit,
	output logic             rx_fec_capability,
	output logic             rx_training_flag,
	output logic [5:0]       rx_tap_status
);
	logic [2:0] gap_q;

	// ----
	// Frame pacing
	// ----
	// One frame every eighth cycle, like a slow but steady far end.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			gap_q <= 3'h0;
		end else begin
			gap_q <= gap_q + 3'h1;
		end
	end

	// Fields show their inverse between frames, so a capture off the strobe is caught.
	assign rx_frame_valid = (gap_q == 3'h7);
	assign word_sync = sync_en;
	assign {rx_preset, rx_initialize, rx_fec_request, rx_tap_update, rx_training_complete,
		rx_fec_capability, rx_training_flag, rx_tap_status} = rx_frame_valid ? fields : ~fields;
	// Readiness is signalled by a zero sequence bit in each frame.
	assign rx_sequence_bit = rx_frame_valid ? !ready : ready;
endmodule

`default_nettype wire

/* test/testbench.sv */
/*
 * Self-checking bench for the training sequencer start-up block.
 * Assumes the remote port model and AXI4-Lite register access.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        clock = 0, resetn = 0, clk_en = 1, sync_en = 0, ready = 0;
	logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        link_wait_start = 0, link_test_start = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, out_ext_marker;
	logic [17:0] fields = 0, in_v, out_v;
	logic        word_sync, rx_frame_valid, rx_preset, rx_initialize, rx_fec_request, rx_training_complete;
	logic        rx_sequence_bit, rx_fec_capability, rx_training_flag;
	logic [5:0]  rx_tap_update, rx_tap_status, in_tap_update, in_tap_status, out_tap_update, out_tap_status;
	logic        in_preset, in_initialize, in_fec_request, in_training_complete, in_sequence_bit;
	logic        in_fec_capability, in_training_flag, out_preset, out_initialize, out_fec_request;
	logic        out_training_complete, out_sequence_bit, out_fec_capability, out_training_flag;
	logic        tx_training_signal, coef_load_init, tap_request_start, tap_answer_start, enter_local;
	logic        train_failed, fail_expired, link_wait_expired, link_test_expired;
	int          error_cnt = 0, total_checks = 0, n_load = 0, n_req = 0, n_ans = 0, n_loc = 0;

	ltts_seq #(.FAIL_CYC(400), .TEST_CYC(100)) dut_u (.*);
	ltts_remote remote_u (.*);

	// Frame variables packed in one order for compact comparison.
	assign in_v = {in_preset, in_initialize, in_fec_request, in_tap_update, in_training_complete,
		in_fec_capability, in_training_flag, in_tap_status};
	assign out_v = {out_preset, out_initialize, out_fec_request, out_tap_update, out_training_complete,
		out_fec_capability, out_training_flag, out_tap_status};

	// A 50 ns clock.
	initial begin
		forever #25 clock = ~clock;
	end

	// Pulses are counted, since they stand for one cycle only.
	always @(posedge clock) begin
		n_load <= n_load + coef_load_init;
		n_req <= n_req + tap_request_start;
		n_ans <= n_ans + tap_answer_start;
		n_loc <= n_loc + enter_local;
	end

	// ----
	// Shared tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Waits as long as the slave needs; only the watchdog ends a hang.
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wait_lvl(ref logic s, output int n);
		n = 0;
		while (s !== 1'b1 && n < 3000) begin
			@(posedge clock);
			n++;
		end
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_init;
		logic [31:0] d;
		int a, r, l;
		a = n_ans;
		r = n_req;
		l = n_load;
		axi_wr(4'h0, 32'h0000003B);
		chk("bresp", 2'h0, s_axi_bresp);
		repeat (6) @(posedge clock);
		chk("in_vars", 32'h00040, in_v);
		chk("in_seq", 1, in_sequence_bit);
		chk("out_vars", 32'h08000, out_v);
		chk("out_seq", 0, out_sequence_bit);
		chk("marker", 2'h3, out_ext_marker);
		chk("pulses", 24'h010101, {8'(n_load - l), 8'(n_req - r), 8'(n_ans - a)});
		axi_rd(4'h4, d);
		chk("status", 32'h41, d & 32'h77);
		$display("test init done");
	endtask

	task automatic t_lock;
		logic [31:0] d;
		int l;
		l = n_loc;
		sync_en <= 1'b1;
		fields <= 18'h2B5C6;
		repeat (20) @(posedge clock);
		chk("captured", 32'h2B5C6, in_v);
		axi_rd(4'h4, d);
		chk("still_init", 1, d[2:0]);
		sync_en <= 1'b0;
		fields <= 18'h14A39;
		ready <= 1'b1;
		repeat (20) @(posedge clock);
		chk("held", 32'h2B5C6, in_v);
		chk("held_seq", 1, in_sequence_bit);
		sync_en <= 1'b1;
		repeat (20) @(posedge clock);
		chk("seq_zero", 0, in_sequence_bit);
		chk("recaptured", 32'h14A39, in_v);
		chk("local_pulse", l + 1, n_loc);
		axi_rd(4'h4, d);
		chk("local_state", 3, d[2:0]);
		$display("test lock done");
	endtask

	task automatic t_fail;
		logic [31:0] d;
		int n, r;
		r = n_req;
		sync_en <= 1'b0;
		ready <= 1'b0;
		axi_wr(4'h0, 32'h00000005);
		repeat (4) @(posedge clock);
		wait_lvl(fail_expired, n);
		chk("fail_window", 1, n >= 396 && n <= 596);
		repeat (3) @(posedge clock);
		chk("failed", 1, train_failed);
		chk("tx_off", 0, tx_training_signal);
		chk("out_vars2", 32'h000C0, out_v);
		chk("marker2", 0, out_ext_marker);
		chk("no_request", r, n_req);
		axi_rd(4'h4, d);
		chk("fail_status", 32'h34, d & 32'h77);
		chk("rresp", 2'h0, s_axi_rresp);
		$display("test fail done");
	endtask

	task automatic t_timers;
		int n;
		link_wait_start <= 1'b1;
		@(posedge clock);
		link_wait_start <= 1'b0;
		wait_lvl(link_wait_expired, n);
		chk("wait_window", 1, n >= 640 && n <= 1920);
		link_test_start <= 1'b1;
		@(posedge clock);
		link_test_start <= 1'b0;
		wait_lvl(link_test_expired, n);
		chk("test_window", 1, n >= 100 && n <= 150);
		$display("test timers done");
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Main sequence after a 16-cycle reset.
	initial begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		t_init;
		t_lock;
		t_fail;
		t_timers;
		wrap_up;
	end

	// The tests need about 1300 cycles; over twenty times that means a hang.
	initial begin
		repeat (30000) @(posedge clock);
		error_cnt++;
		wrap_up;
	end
endmodule

`default_nettype wire
